// [urs_pkg.sv]
// Shared constants and carrier types for the dual-channel register select block
package urs_pkg;

  // Register addresses, named by the normal page occupant
  localparam logic [2:0] ADDR_DATA    = 3'h0; // Holding / divisor low / trigger
  localparam logic [2:0] ADDR_IRQEN   = 3'h1; // Irq enable / divisor high / feature
  localparam logic [2:0] ADDR_IRQST   = 3'h2; // Irq status, fifo control / enhanced
  localparam logic [2:0] ADDR_LINE    = 3'h3; // Line control, every page
  localparam logic [2:0] ADDR_MODEM   = 3'h4; // Modem control / resume one
  localparam logic [2:0] ADDR_LSTAT   = 3'h5; // Line status / resume two
  localparam logic [2:0] ADDR_MSTAT   = 3'h6; // Modem status / pause one
  localparam logic [2:0] ADDR_SCRATCH = 3'h7; // Scratch, level view / pause two

  // Page selection values and bit positions
  localparam logic [7:0] LCR_ENH_KEY   = 8'hBF;
  localparam int         LCR_DIV_BIT   = 7;
  localparam int         FEATURE_CONTROL_SWAP_BIT = 6;
  localparam int         EFR_ENH_BIT   = 4;

  // Extended bits gated by the enhanced-function enable
  localparam logic [7:0] IER_EXT_MASK = 8'hF0;
  localparam logic [7:0] ISR_EXT_MASK = 8'h30;
  localparam logic [7:0] FCR_EXT_MASK = 8'h30;
  localparam logic [7:0] MCR_EXT_MASK = 8'hE0;

  // Reset value of every stored byte, and the all-zero divisor test value
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Identity bytes, values are arbitrary
  localparam logic [7:0] REV_CODE_DEF = 8'h01;
  localparam logic [7:0] DEV_ID_DEF   = 8'h5A;

  // Host-written configuration of one channel
  typedef struct packed {
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [7:0] irqEnable;
    logic [7:0] fifoControl;
    logic [7:0] lineControl;
    logic [7:0] modemControl;
    logic [7:0] scratchByte;
    logic [7:0] extModeSelect;
    logic [7:0] fifoTriggerSet;
    logic [7:0] featureControl;
    logic [7:0] enhancedFunction;
    logic [7:0] resumeCharOne;
    logic [7:0] resumeCharTwo;
    logic [7:0] pauseCharOne;
    logic [7:0] pauseCharTwo;
  } urs_config_s;

  // Status supplied by the channel core
  typedef struct packed {
    logic [7:0] rxHolding;
    logic [7:0] irqStatus;
    logic [7:0] lineStatus;
    logic [7:0] modemStatus;
    logic [7:0] fifoLevel;
  } urs_status_s;

  // One-cycle access side effects, one bit per channel
  typedef struct packed {
    logic [1:0] txLoad;
    logic [1:0] fifoCtlLoad;
    logic [1:0] trigLoad;
    logic [1:0] rxPop;
    logic [1:0] irqStatusRead;
    logic [1:0] lineStatusRead;
    logic [1:0] modemStatusRead;
  } urs_event_s;

  // Entire state of the block
  typedef struct packed {
    urs_config_s [1:0] cfg;
    logic [7:0]        txData;
    logic [7:0]        rdData;
    logic              rdValid;
    urs_event_s        ev;
  } urs_state_s;

endpackage : urs_pkg

// [urs_reg_select.sv]
// Register address decode and register map for both channels of a dual UART
`timescale 1ns/1ps

module urs_reg_select #(
  parameter logic [7:0] REV_CODE = urs_pkg::REV_CODE_DEF, // Arbitrary revision byte
  parameter logic [7:0] DEV_ID   = urs_pkg::DEV_ID_DEF    // Arbitrary identity byte
) (
  input  wire logic                      clock,           // 20 MHz clock
  input  wire logic                      rst,             // Async reset, high
  input  wire logic                      chanOneSelectN,  // Channel one select, low
  input  wire logic                      chanTwoSelectN,  // Channel two select, low
  input  wire logic [2:0]                regAddress,      // Register address
  input  wire logic                      readStrobe,      // Read request pulse
  input  wire logic                      writeStrobe,     // Write request pulse
  input  wire logic [7:0]                writeData,       // Write byte
  input  urs_pkg::urs_status_s [1:0]     chanStatus,      // Core status per channel
  output logic [7:0]                     readData,        // Read byte, registered
  output logic                           readValid,       // Read answer pulse
  output logic [7:0]                     txData,          // Byte for transmitter
  output urs_pkg::urs_config_s [1:0]     chanConfig,      // Effective configuration
  output urs_pkg::urs_event_s            chanEvent        // Access side effects
);

  urs_pkg::urs_state_s st_ff;
  urs_pkg::urs_state_s nxt_st;

  logic [1:0] chanHit;
  logic       accessOk;
  logic [7:0] rdMux     [2];
  logic [1:0] enhPage;
  logic [1:0] divPage;
  logic [1:0] enhEnable;
  logic [1:0] scratchSwap;

  // Exactly one select low picks a channel; both low is refused as ambiguous
  assign chanHit[0] = !chanOneSelectN && chanTwoSelectN;
  assign chanHit[1] = chanOneSelectN && !chanTwoSelectN;
  // A request with both strobes at once is not a byte access and is dropped
  assign accessOk   = (readStrobe ^ writeStrobe) && (chanHit != 2'h0);

  // Per-channel page flags and read multiplexer
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    urs_pkg::urs_config_s cf;
    urs_pkg::urs_status_s sv;
    logic                 zeroDiv;
    assign cf = st_ff.cfg[c];
    assign sv = chanStatus[c];
    assign enhPage[c]     = cf.lineControl == urs_pkg::LCR_ENH_KEY;
    assign divPage[c]     = cf.lineControl[urs_pkg::LCR_DIV_BIT] && !enhPage[c];
    assign enhEnable[c]   = cf.enhancedFunction[urs_pkg::EFR_ENH_BIT];
    assign scratchSwap[c] = cf.featureControl[urs_pkg::FEATURE_CONTROL_SWAP_BIT];
    assign zeroDiv = (cf.divLow == urs_pkg::RESET_BYTE)
                  && (cf.divHigh == urs_pkg::RESET_BYTE);

    // Read value as seen by the page in force at the strobe
    always_comb
    begin
      rdMux[c] = urs_pkg::RESET_BYTE;
      case (regAddress)
        urs_pkg::ADDR_DATA:
        begin
          if (enhPage[c])
            rdMux[c] = sv.fifoLevel;
          else if (divPage[c] && zeroDiv)
            rdMux[c] = REV_CODE;
          else if (divPage[c])
            rdMux[c] = cf.divLow;
          else
            rdMux[c] = sv.rxHolding;
        end
        urs_pkg::ADDR_IRQEN:
        begin
          if (enhPage[c])
            rdMux[c] = cf.featureControl;
          else if (divPage[c] && zeroDiv)
            rdMux[c] = DEV_ID;
          else if (divPage[c])
            rdMux[c] = cf.divHigh;
          else if (enhEnable[c])
            rdMux[c] = cf.irqEnable;
          else
            rdMux[c] = cf.irqEnable & ~urs_pkg::IER_EXT_MASK;
        end
        urs_pkg::ADDR_IRQST:
        begin
          if (enhPage[c])
            rdMux[c] = cf.enhancedFunction;
          else if (enhEnable[c])
            rdMux[c] = sv.irqStatus;
          else
            rdMux[c] = sv.irqStatus & ~urs_pkg::ISR_EXT_MASK;
        end
        urs_pkg::ADDR_LINE:
          rdMux[c] = cf.lineControl;
        urs_pkg::ADDR_MODEM:
        begin
          if (enhPage[c])
            rdMux[c] = cf.resumeCharOne;
          else if (enhEnable[c])
            rdMux[c] = cf.modemControl;
          else
            rdMux[c] = cf.modemControl & ~urs_pkg::MCR_EXT_MASK;
        end
        urs_pkg::ADDR_LSTAT:
          rdMux[c] = enhPage[c] ? cf.resumeCharTwo : sv.lineStatus;
        urs_pkg::ADDR_MSTAT:
          rdMux[c] = enhPage[c] ? cf.pauseCharOne : sv.modemStatus;
        urs_pkg::ADDR_SCRATCH:
        begin
          if (enhPage[c])
            rdMux[c] = cf.pauseCharTwo;
          else if (scratchSwap[c])
            rdMux[c] = sv.fifoLevel;
          else
            rdMux[c] = cf.scratchByte;
        end
        default:
          rdMux[c] = urs_pkg::RESET_BYTE;
      endcase
    end

    // Extended bits are withheld from the core while the enable is clear
    always_comb
    begin
      chanConfig[c] = cf;
      if (!enhEnable[c])
      begin
        chanConfig[c].irqEnable    = cf.irqEnable & ~urs_pkg::IER_EXT_MASK;
        chanConfig[c].fifoControl  = cf.fifoControl & ~urs_pkg::FCR_EXT_MASK;
        chanConfig[c].modemControl = cf.modemControl & ~urs_pkg::MCR_EXT_MASK;
      end
    end
  end

  // Next-state logic: writes land in the selected channel only
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.ev      = '0;
    nxt_st.rdValid = 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      if (accessOk && chanHit[c] && readStrobe)
      begin
        // Read answer and the pops and clears a core expects from reads
        nxt_st.rdData  = rdMux[c];
        nxt_st.rdValid = 1'b1;
        case (regAddress)
          urs_pkg::ADDR_DATA:
            nxt_st.ev.rxPop[c] = !enhPage[c] && !divPage[c];
          urs_pkg::ADDR_IRQST:
            nxt_st.ev.irqStatusRead[c] = !enhPage[c];
          urs_pkg::ADDR_LSTAT:
            nxt_st.ev.lineStatusRead[c] = !enhPage[c];
          urs_pkg::ADDR_MSTAT:
            nxt_st.ev.modemStatusRead[c] = !enhPage[c];
          default:
            nxt_st.ev.rxPop[c] = 1'b0;
        endcase
      end
      if (accessOk && chanHit[c] && writeStrobe)
      begin
        case (regAddress)
          urs_pkg::ADDR_DATA:
          begin
            if (enhPage[c])
            begin
              nxt_st.cfg[c].fifoTriggerSet = writeData;
              nxt_st.ev.trigLoad[c]        = 1'b1;
            end
            else if (divPage[c])
              nxt_st.cfg[c].divLow = writeData;
            else
            begin
              nxt_st.txData        = writeData;
              nxt_st.ev.txLoad[c]  = 1'b1;
            end
          end
          urs_pkg::ADDR_IRQEN:
          begin
            if (enhPage[c])
              nxt_st.cfg[c].featureControl = writeData;
            else if (divPage[c])
              nxt_st.cfg[c].divHigh = writeData;
            else
              nxt_st.cfg[c].irqEnable = writeData;
          end
          urs_pkg::ADDR_IRQST:
          begin
            if (enhPage[c])
              nxt_st.cfg[c].enhancedFunction = writeData;
            else
            begin
              nxt_st.cfg[c].fifoControl = writeData;
              nxt_st.ev.fifoCtlLoad[c]  = 1'b1;
            end
          end
          urs_pkg::ADDR_LINE:
            nxt_st.cfg[c].lineControl = writeData;
          urs_pkg::ADDR_MODEM:
          begin
            if (enhPage[c])
              nxt_st.cfg[c].resumeCharOne = writeData;
            else
              nxt_st.cfg[c].modemControl = writeData;
          end
          urs_pkg::ADDR_LSTAT:
          begin
            // Outside the enhanced page this write is reserved and dropped
            if (enhPage[c])
              nxt_st.cfg[c].resumeCharTwo = writeData;
          end
          urs_pkg::ADDR_MSTAT:
          begin
            if (enhPage[c])
              nxt_st.cfg[c].pauseCharOne = writeData;
          end
          urs_pkg::ADDR_SCRATCH:
          begin
            if (enhPage[c])
              nxt_st.cfg[c].pauseCharTwo = writeData;
            else if (scratchSwap[c])
              nxt_st.cfg[c].extModeSelect = writeData;
            else
              nxt_st.cfg[c].scratchByte = writeData;
          end
          default:
            nxt_st.cfg[c] = st_ff.cfg[c];
        endcase
      end
    end
  end

  // State register; every stored byte starts from zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign readData  = st_ff.rdData;
  assign readValid = st_ff.rdValid;
  assign txData    = st_ff.txData;
  assign chanEvent = st_ff.ev;

endmodule : urs_reg_select

// [urs_reg_select_asserts.sv]
// Port-level checks for the register select block
`timescale 1ns/1ps
module urs_reg_select_asserts (
  input wire logic                  clock,          // Clock
  input wire logic                  rst,            // Async reset
  input wire logic                  chanOneSelectN, // Channel one select
  input wire logic                  chanTwoSelectN, // Channel two select
  input wire logic [2:0]            regAddress,     // Register address
  input wire logic                  readStrobe,     // Read pulse
  input wire logic                  writeStrobe,    // Write pulse
  input wire logic [7:0]            writeData,      // Write byte
  input urs_pkg::urs_status_s [1:0] chanStatus,     // Core status
  input wire logic [7:0]            readData,       // Read byte
  input wire logic                  readValid,      // Read answer
  input wire logic [7:0]            txData,         // Transmit byte
  input urs_pkg::urs_config_s [1:0] chanConfig,     // Configuration
  input urs_pkg::urs_event_s        chanEvent       // Side effects
);
  logic       oneSel;
  logic       rdTake;
  logic       wrTake;
  logic [7:0] lcr0;
  // Accepted accesses: exactly one select and exactly one strobe
  assign oneSel = chanOneSelectN ^ chanTwoSelectN;
  assign rdTake = oneSel && readStrobe && !writeStrobe;
  assign wrTake = oneSel && writeStrobe && !readStrobe;
  assign lcr0   = chanConfig[0].lineControl;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (rdTake |=> readValid)
    else $error("read not answered in next cycle");
  chk_no_stray: assert property (!rdTake |=> !readValid)
    else $error("answer without accepted read");
  chk_line_read: assert property (rdTake && !chanOneSelectN && regAddress == 3'h3
    |=> readData == $past(lcr0)) else $error("line control readback wrong");
  chk_tx_load: assert property (wrTake && !chanOneSelectN && regAddress == 3'h0
    && !lcr0[7] |=> txData == $past(writeData) && chanEvent.txLoad == 2'h1)
    else $error("transmit byte not loaded");
  chk_lstat_read: assert property (rdTake && !chanTwoSelectN && regAddress == 3'h5
    && chanConfig[1].lineControl != 8'hBF |=> readData == $past(chanStatus[1].lineStatus))
    else $error("line status read wrong");
  chk_ext_masked: assert property (!chanConfig[0].enhancedFunction[4]
    |-> (chanConfig[0].irqEnable & urs_pkg::IER_EXT_MASK) == 8'h00)
    else $error("extended enable bits visible");
  chk_refused_quiet: assert property ((readStrobe || writeStrobe) && !rdTake && !wrTake
    |=> !readValid && chanConfig == $past(chanConfig)) else $error("refused access acted");
  chk_scratch_wr: assert property (wrTake && !chanTwoSelectN && regAddress == 3'h7
    && chanConfig[1].lineControl != 8'hBF && !chanConfig[1].featureControl[6]
    |=> chanConfig[1].scratchByte == $past(writeData)) else $error("scratch not written");
endmodule : urs_reg_select_asserts
bind urs_reg_select urs_reg_select_asserts i_urs_reg_select_asserts (
  .clock(clock), .rst(rst), .chanOneSelectN(chanOneSelectN), .chanTwoSelectN(chanTwoSelectN),
  .regAddress(regAddress), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
  .writeData(writeData), .chanStatus(chanStatus), .readData(readData),
  .readValid(readValid), .txData(txData), .chanConfig(chanConfig), .chanEvent(chanEvent));

// [urs_host_model.sv]
// Host bus model issuing single byte accesses on the falling edge
`timescale 1ns/1ps
module urs_host_model (
  input  wire logic       clock,       // Bus clock
  input  wire logic [7:0] readData,    // Read byte
  input  wire logic       readValid,   // Read answer
  output logic [1:0]      selN,        // Selects, bit 0 is channel one
  output logic [2:0]      regAddress,  // Register address
  output logic            readStrobe,  // Read pulse
  output logic            writeStrobe, // Write pulse
  output logic [7:0]      writeData    // Write byte
);
  // Idle bus at time zero
  initial
  begin
    selN = 2'h3;
    regAddress = 3'h0;
    readStrobe = 1'b0;
    writeStrobe = 1'b0;
    writeData = 8'h00;
  end
  // One write; data is scrambled after release so stale bytes never look valid
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    selN = s;
    regAddress = a;
    writeData = d;
    writeStrobe = 1'b1;
    @(negedge clock);
    writeStrobe = 1'b0;
    selN = 2'h3;
    writeData = ~d;
  endtask : wr
  // One read; the answer stands one cycle only, so it is taken right away
  task automatic rd(input logic [1:0] s, input logic [2:0] a,
                    output logic [7:0] q, output logic v);
    @(negedge clock);
    selN = s;
    regAddress = a;
    readStrobe = 1'b1;
    @(negedge clock);
    readStrobe = 1'b0;
    selN = 2'h3;
    q = readData;
    v = readValid;
  endtask : rd
endmodule : urs_host_model

// [urs_reg_select_tb.sv]
// Self-checking testbench for the register select block
`timescale 1ns/1ps
module urs_reg_select_tb;
  localparam logic [1:0] ONE = 2'h2;
  localparam logic [1:0] TWO = 2'h1;
  logic                       clock;
  logic                       rst;
  logic [1:0]                 selN;
  logic [2:0]                 regAddress;
  logic                       readStrobe;
  logic                       writeStrobe;
  logic [7:0]                 writeData;
  logic [7:0]                 readData;
  logic [7:0]                 txData;
  logic                       readValid;
  urs_pkg::urs_status_s [1:0] chanStatus;
  urs_pkg::urs_config_s [1:0] chanConfig;
  urs_pkg::urs_config_s [1:0] snap;
  urs_pkg::urs_event_s        chanEvent;
  int                         errCount;
  int                         checksDone;
  // 50 ns clock
  initial clock = 1'b0;
  always #25 clock = ~clock;
  urs_reg_select i_urs_reg_select (.clock(clock), .rst(rst), .chanOneSelectN(selN[0]),
    .chanTwoSelectN(selN[1]), .regAddress(regAddress), .readStrobe(readStrobe),
    .writeStrobe(writeStrobe), .writeData(writeData), .chanStatus(chanStatus),
    .readData(readData), .readValid(readValid), .txData(txData), .chanConfig(chanConfig),
    .chanEvent(chanEvent));
  urs_host_model i_urs_host_model (.clock(clock), .readData(readData), .readValid(readValid),
    .selN(selN), .regAddress(regAddress), .readStrobe(readStrobe),
    .writeStrobe(writeStrobe), .writeData(writeData));
  // Byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read with answer check; events of the read still stand on return
  task automatic rdc(input logic [1:0] s, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       v;
    i_urs_host_model.rd(s, a, q, v);
    chk({7'h00, v}, 8'h01);
    chk(q, exp);
  endtask : rdc
  // Whole configuration unchanged
  task automatic same_cfg();
    for (int i = 0; i < $bits(snap); i += 8)
      chk(chanConfig[i/8/15][(i%120)+:8], snap[i/8/15][(i%120)+:8]);
  endtask : same_cfg
  task automatic t_normal();
    rdc(ONE, 3'h3, 8'h00);
    i_urs_host_model.wr(ONE, 3'h0, 8'h55);
    chk(txData, 8'h55);
    chk({6'h00, chanEvent.txLoad}, 8'h01);
    rdc(ONE, 3'h0, 8'h3C);
    chk({6'h00, chanEvent.rxPop}, 8'h01);
    i_urs_host_model.wr(ONE, 3'h1, 8'hFF);
    rdc(ONE, 3'h1, 8'h0F);
    rdc(ONE, 3'h2, 8'h0C);
    chk({6'h00, chanEvent.irqStatusRead}, 8'h01);
    i_urs_host_model.wr(ONE, 3'h2, 8'h31);
    chk({6'h00, chanEvent.fifoCtlLoad}, 8'h01);
    chk(chanConfig[0].fifoControl, 8'h01);
    i_urs_host_model.wr(ONE, 3'h4, 8'hE3);
    rdc(ONE, 3'h4, 8'h03);
    rdc(ONE, 3'h5, 8'h60);
    chk({6'h00, chanEvent.lineStatusRead}, 8'h01);
    rdc(ONE, 3'h6, 8'hB0);
    chk({6'h00, chanEvent.modemStatusRead}, 8'h01);
    rdc(TWO, 3'h5, 8'h61);
    chk({6'h00, chanEvent.lineStatusRead}, 8'h02);
    i_urs_host_model.wr(TWO, 3'h7, 8'h77);
    rdc(TWO, 3'h7, 8'h77);
    chk(chanConfig[0].scratchByte, 8'h00);
    $display("test normal page done");
  endtask : t_normal
  task automatic t_divisor();
    i_urs_host_model.wr(ONE, 3'h3, 8'h80);
    i_urs_host_model.wr(ONE, 3'h0, 8'h12);
    i_urs_host_model.wr(ONE, 3'h1, 8'h34);
    rdc(ONE, 3'h0, 8'h12);
    chk({6'h00, chanEvent.rxPop}, 8'h00);
    rdc(ONE, 3'h1, 8'h34);
    chk(txData, 8'h55);
    i_urs_host_model.wr(ONE, 3'h0, 8'h00);
    i_urs_host_model.wr(ONE, 3'h1, 8'h00);
    rdc(ONE, 3'h0, urs_pkg::REV_CODE_DEF);
    rdc(ONE, 3'h1, urs_pkg::DEV_ID_DEF);
    rdc(ONE, 3'h3, 8'h80);
    $display("test divisor page done");
  endtask : t_divisor
  task automatic t_enhanced();
    i_urs_host_model.wr(ONE, 3'h3, 8'hBF);
    i_urs_host_model.wr(ONE, 3'h1, 8'h40);
    i_urs_host_model.wr(ONE, 3'h2, 8'h10);
    for (int i = 4; i < 8; i++)
      i_urs_host_model.wr(ONE, 3'(i), 8'hA0 + 8'(i));
    for (int i = 4; i < 8; i++)
      rdc(ONE, 3'(i), 8'hA0 + 8'(i));
    chk(chanConfig[0].resumeCharOne, 8'hA4);
    chk(chanConfig[0].pauseCharTwo, 8'hA7);
    rdc(ONE, 3'h1, 8'h40);
    rdc(ONE, 3'h2, 8'h10);
    i_urs_host_model.wr(ONE, 3'h0, 8'h5C);
    chk({6'h00, chanEvent.trigLoad}, 8'h01);
    chk(chanConfig[0].fifoTriggerSet, 8'h5C);
    rdc(ONE, 3'h0, 8'h21);
    rdc(ONE, 3'h3, 8'hBF);
    $display("test enhanced page done");
  endtask : t_enhanced
  task automatic t_swap();
    i_urs_host_model.wr(ONE, 3'h3, 8'h03);
    rdc(ONE, 3'h7, 8'h21);
    i_urs_host_model.wr(ONE, 3'h7, 8'h9E);
    chk(chanConfig[0].extModeSelect, 8'h9E);
    chk(chanConfig[0].scratchByte, 8'h00);
    i_urs_host_model.wr(ONE, 3'h1, 8'hF3);
    rdc(ONE, 3'h1, 8'hF3);
    rdc(ONE, 3'h2, 8'h3C);
    chk(chanConfig[0].fifoControl, 8'h31);
    snap = chanConfig;
    i_urs_host_model.wr(ONE, 3'h5, 8'hFF);
    i_urs_host_model.wr(ONE, 3'h6, 8'hFF);
    same_cfg();
    $display("test swap and reserved done");
  endtask : t_swap
  task automatic t_refuse();
    logic [7:0] q;
    logic       v;
    snap = chanConfig;
    i_urs_host_model.wr(2'h0, 3'h7, 8'hEE);
    i_urs_host_model.wr(2'h3, 3'h7, 8'hEE);
    same_cfg();
    i_urs_host_model.rd(2'h0, 3'h3, q, v);
    chk({7'h00, v}, 8'h00);
    $display("test refused access done");
  endtask : t_refuse
  // Verdict and end of run
  task automatic finalReport();
    $display("checks=%0d errors=%0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finalReport
  // Main sequence; status bytes carry extended bits so masking is visible
  initial
  begin
    rst = 1'b1;
    errCount = 0;
    checksDone = 0;
    chanStatus[0] = {8'h3C, 8'h3C, 8'h60, 8'hB0, 8'h21};
    chanStatus[1] = {8'hC3, 8'h01, 8'h61, 8'h0F, 8'h12};
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_normal();
    t_divisor();
    t_enhanced();
    t_swap();
    t_refuse();
    finalReport();
  end
endmodule : urs_reg_select_tb
